//--- logic/pwic_edge_det.sv
// port-B pin synchroniser and selected-edge detector
module pwic_edge_det #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pins,
  pwic_edge_if.det edge_bus
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_d;
  logic [WIDTH-1:0] prev_d;

  initial begin
    if (WIDTH < 1) $error("pwic_edge_det: WIDTH must be at least 1");
  end

  always_comb begin
    meta_d = pins;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // hit is one cycle per edge because it compares two settled samples
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      edge_bus.hit[i] = edge_bus.falling_sel[i] ? (prev_q[i] & ~sync_q[i])
                                                : (~prev_q[i] & sync_q[i]);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end
endmodule

//--- logic/pwic_edge_if.sv
// carries port-B edge selection and detected edges between the sequencer and the detector
interface pwic_edge_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] falling_sel;
  logic [WIDTH-1:0] hit;
  modport det (input falling_sel, output hit);
  modport ctl (output falling_sel, input hit);
endinterface

//--- logic/pwic_pkg.sv
// constants for the power-down, wake-up and interrupt sequencer block
// Functional notes
// - low-power state is entered only by the sleep instruction strobe.
// - in sleep, main clock stays on only when config word bit 11 is clear.
// - sleep with watchdog enabled clears watchdog, sets timeout, clears powerdown flag.
// - sleep ends on watchdog overflow, enabled port-B edge, or external reset pin.
// - a cleared wake enable mask bit enables its pin; a set bit disables.
// - a set edge select bit picks falling edges; cleared picks rising edges.
// - reset loads enable mask and edge select with all ones.
// - selected pin edge latches a one in its pending bit until software clears.
// - a port-B wake forces the program counter to the top address.
// - writes to pending or comparator swap with the accumulator; others plain move.
// - mode 19h or 09h pending, 1Ah edge, 1Bh enable, 1Fh direction.
// - while running, enabled port-B pending bits raise a maskable interrupt.
// - accept counter rollover when enabled and overflow, compare, capture per timer.
// - sources have equal priority; after acknowledge, block all until return.
// - acknowledge saves pc, pointer, status, mode, accumulator and vectors to 0.
// - status driven out at acknowledge has its three page select bits cleared; the saved copy keeps them.
// - interrupt return restores pc and context, re-enabling interrupts.
// - variant return also adds the accumulator to the real-time counter.
// - a port-B edge during service pends at once and is taken after return.
// - timer events during service are dropped and never interrupt later.
package pwic_pkg;
  localparam logic [7:0] MODE_PEND = 8'h19;
  localparam logic [7:0] MODE_PEND_ALT = 8'h09;
  localparam logic [7:0] MODE_EDGE = 8'h1a;
  localparam logic [7:0] MODE_EN = 8'h1b;
  localparam logic [7:0] MODE_DIR = 8'h1f;
  localparam logic [7:0] MODE_CMP = 8'h18;
  localparam logic [7:0] WAKE_RST = 8'hff;
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [7:0] PEND_RST = 8'h00;
  localparam int CFG_CLK_KEEP_BIT = 11;
  localparam int STATUS_PAGE_LSB = 5;
  localparam int PAGE_BITS = 3;
  localparam int TIMER_SRCS = 6;
  typedef enum logic [0:0] {
    PWIC_RUN = 1'b0,
    PWIC_SLEEP = 1'b1
  } pwic_state_t;
endpackage

//--- logic/pwic_top.sv
// power-down control, port-B wake-up and interrupt context sequencer
module pwic_top #(
  parameter int PC_WIDTH = 12,
  parameter int CFG_WIDTH = 12
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] second_port_pins,
  input wire logic external_reset_pin,
  input wire logic sleep_exec,
  input wire logic watchdog_enable,
  input wire logic watchdog_overflow,
  input wire logic [CFG_WIDTH-1:0] extended_config_word,
  input wire logic cfg_wr,
  input wire logic [7:0] mode_reg,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic cfg_swap,
  output logic [7:0] direction_reg,
  output logic [7:0] comparator_register,
  input wire logic rtc_rollover,
  input wire logic rtc_irq_enable,
  input wire logic [pwic_pkg::TIMER_SRCS-1:0] timer_events,
  output logic irq_req,
  input wire logic irq_ack,
  input wire logic [PC_WIDTH-1:0] pc_in,
  input wire logic [7:0] fsp_in,
  input wire logic [7:0] status_in,
  input wire logic [7:0] mode_in,
  input wire logic [7:0] w_in,
  input wire logic return_from_irq,
  input wire logic return_irq_add_counter,
  output logic pc_load,
  output logic [PC_WIDTH-1:0] pc_value,
  output logic ctx_load,
  output logic [7:0] fsp_out,
  output logic [7:0] status_out,
  output logic [7:0] mode_out,
  output logic [7:0] w_out,
  output logic rtc_add,
  output logic [7:0] rtc_add_val,
  output logic low_power,
  output logic main_clk_keep,
  output logic watchdog_clear,
  output logic timeout_flag_set,
  output logic powerdown_flag_clr,
  output logic wake_reset,
  output logic in_service,
  output logic [7:0] wake_pending_flags,
  output logic [7:0] wake_enable_mask,
  output logic [7:0] wake_edge_select
);
  localparam logic [PC_WIDTH-1:0] PC_TOP = '1;
  localparam logic [PC_WIDTH-1:0] PC_VECTOR = '0;

  initial begin
    if (PC_WIDTH < 1 || PC_WIDTH > 16) $error("pwic_top: PC_WIDTH out of range");
    if (CFG_WIDTH <= pwic_pkg::CFG_CLK_KEEP_BIT) $error("pwic_top: CFG_WIDTH too small");
  end

  // port-B edge detection
  pwic_edge_if #(.WIDTH(8)) edge_bus ();
  assign edge_bus.falling_sel = wake_edge_select;

  pwic_edge_det #(.WIDTH(8)) u_edge (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pins(second_port_pins),
    .edge_bus(edge_bus)
  );

  // external reset pin comes from outside the clock domain
  logic rst_pin_meta_q;
  logic rst_pin_sync_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_pin_meta_q <= 1'b0;
      rst_pin_sync_q <= 1'b0;
    end else begin
      rst_pin_meta_q <= external_reset_pin;
      rst_pin_sync_q <= rst_pin_meta_q;
    end
  end

  // configuration registers reached through the port-B configuration write
  logic [7:0] en_q, en_d;
  logic [7:0] edge_q, edge_d;
  logic [7:0] pend_q, pend_d;
  logic [7:0] dir_q, dir_d;
  logic [7:0] cmp_q, cmp_d;
  logic [7:0] rdata_q, rdata_d;
  logic swap_q, swap_d;
  logic sel_pend;
  logic sel_cmp;

  assign sel_pend = (mode_reg == pwic_pkg::MODE_PEND) || (mode_reg == pwic_pkg::MODE_PEND_ALT);
  assign sel_cmp = mode_reg == pwic_pkg::MODE_CMP;

  always_comb begin
    en_d = en_q;
    edge_d = edge_q;
    dir_d = dir_q;
    cmp_d = cmp_q;
    rdata_d = rdata_q;
    swap_d = 1'b0;
    // a hardware edge in the write cycle survives the software clear
    pend_d = pend_q | edge_bus.hit;
    if (cfg_wr) begin
      unique case (1'b1)
        sel_pend: begin
          rdata_d = pend_q;
          swap_d = 1'b1;
          pend_d = cfg_wdata | edge_bus.hit;
        end
        sel_cmp: begin
          rdata_d = cmp_q;
          swap_d = 1'b1;
          cmp_d = cfg_wdata;
        end
        mode_reg == pwic_pkg::MODE_EDGE: edge_d = cfg_wdata;
        mode_reg == pwic_pkg::MODE_EN: en_d = cfg_wdata;
        mode_reg == pwic_pkg::MODE_DIR: dir_d = cfg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_q <= pwic_pkg::WAKE_RST;
      edge_q <= pwic_pkg::WAKE_RST;
      pend_q <= pwic_pkg::PEND_RST;
      dir_q <= pwic_pkg::DIR_RST;
      cmp_q <= pwic_pkg::CMP_RST;
      rdata_q <= '0;
      swap_q <= 1'b0;
    end else begin
      en_q <= en_d;
      edge_q <= edge_d;
      pend_q <= pend_d;
      dir_q <= dir_d;
      cmp_q <= cmp_d;
      rdata_q <= rdata_d;
      swap_q <= swap_d;
    end
  end

  assign wake_enable_mask = en_q;
  assign wake_edge_select = edge_q;
  assign wake_pending_flags = pend_q;
  assign direction_reg = dir_q;
  assign comparator_register = cmp_q;
  assign cfg_rdata = rdata_q;
  assign cfg_swap = swap_q;

  // enabled pending bits: a cleared mask bit lets its pin through
  logic portb_active;
  assign portb_active = |(pend_q & ~en_q);

  // power-down sequencing
  pwic_pkg::pwic_state_t state_q, state_d;
  logic wdclr_d, wdclr_q;
  logic tmo_set_d, tmo_set_q;
  logic pwrdn_clr_d, pwrdn_clr_q;
  logic wake_rst_d, wake_rst_q;
  logic wake_pc_d;

  always_comb begin
    state_d = state_q;
    wdclr_d = 1'b0;
    tmo_set_d = 1'b0;
    pwrdn_clr_d = 1'b0;
    wake_rst_d = 1'b0;
    wake_pc_d = 1'b0;
    unique case (state_q)
      pwic_pkg::PWIC_RUN: begin
        if (sleep_exec) begin
          state_d = pwic_pkg::PWIC_SLEEP;
          wdclr_d = watchdog_enable;
          tmo_set_d = watchdog_enable;
          pwrdn_clr_d = watchdog_enable;
        end
      end
      pwic_pkg::PWIC_SLEEP: begin
        if (rst_pin_sync_q || (watchdog_enable && watchdog_overflow)) begin
          state_d = pwic_pkg::PWIC_RUN;
          wake_rst_d = 1'b1;
        end else if (portb_active) begin
          state_d = pwic_pkg::PWIC_RUN;
          wake_pc_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= pwic_pkg::PWIC_RUN;
      wdclr_q <= 1'b0;
      tmo_set_q <= 1'b0;
      pwrdn_clr_q <= 1'b0;
      wake_rst_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wdclr_q <= wdclr_d;
      tmo_set_q <= tmo_set_d;
      pwrdn_clr_q <= pwrdn_clr_d;
      wake_rst_q <= wake_rst_d;
    end
  end

  assign low_power = state_q == pwic_pkg::PWIC_SLEEP;
  // in sleep, main clock held only when the keep bit is clear; other clocks are the watchdog's own
  assign main_clk_keep = ~low_power | ~extended_config_word[pwic_pkg::CFG_CLK_KEEP_BIT];
  assign watchdog_clear = wdclr_q;
  assign timeout_flag_set = tmo_set_q;
  assign powerdown_flag_clr = pwrdn_clr_q;
  assign wake_reset = wake_rst_q;

  // interrupt sources and context save/restore
  logic svc_q, svc_d;
  logic tmr_q, tmr_d;
  logic rtc_q, rtc_d;
  logic take;
  logic ret;
  logic [PC_WIDTH-1:0] pc_stk_q, pc_stk_d;
  logic [7:0] fsp_sh_q, fsp_sh_d;
  logic [7:0] st_sh_q, st_sh_d;
  logic [7:0] mode_sh_q, mode_sh_d;
  logic [7:0] w_sh_q, w_sh_d;
  logic pc_load_q, pc_load_d;
  logic [PC_WIDTH-1:0] pc_val_q, pc_val_d;
  logic ctx_q, ctx_d;
  logic [7:0] st_out_q, st_out_d;
  logic rtc_add_q, rtc_add_d;
  logic [7:0] rtc_val_q, rtc_val_d;

  assign irq_req = ~svc_q && ~low_power && (portb_active || tmr_q || rtc_q);
  assign take = irq_req && irq_ack;
  assign ret = svc_q && (return_from_irq || return_irq_add_counter);

  always_comb begin
    svc_d = svc_q;
    // timer events seen during service are dropped for good
    tmr_d = tmr_q | (~svc_q & |timer_events);
    rtc_d = rtc_q | (~svc_q & rtc_rollover & rtc_irq_enable);
    pc_stk_d = pc_stk_q;
    fsp_sh_d = fsp_sh_q;
    st_sh_d = st_sh_q;
    mode_sh_d = mode_sh_q;
    w_sh_d = w_sh_q;
    pc_load_d = wake_pc_d;
    pc_val_d = wake_pc_d ? PC_TOP : pc_val_q;
    ctx_d = 1'b0;
    st_out_d = st_out_q;
    rtc_add_d = 1'b0;
    rtc_val_d = rtc_val_q;
    if (take) begin
      svc_d = 1'b1;
      tmr_d = 1'b0;
      rtc_d = 1'b0;
      pc_stk_d = pc_in;
      fsp_sh_d = fsp_in;
      st_sh_d = status_in;
      mode_sh_d = mode_in;
      w_sh_d = w_in;
      pc_load_d = 1'b1;
      pc_val_d = PC_VECTOR;
      st_out_d = status_in;
      st_out_d[pwic_pkg::STATUS_PAGE_LSB +: pwic_pkg::PAGE_BITS] = '0;
    end else if (ret) begin
      svc_d = 1'b0;
      pc_load_d = 1'b1;
      pc_val_d = pc_stk_q;
      ctx_d = 1'b1;
      st_out_d = st_sh_q;
      rtc_add_d = return_irq_add_counter;
      rtc_val_d = w_in;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      svc_q <= 1'b0;
      tmr_q <= 1'b0;
      rtc_q <= 1'b0;
      pc_stk_q <= '0;
      fsp_sh_q <= '0;
      st_sh_q <= '0;
      mode_sh_q <= '0;
      w_sh_q <= '0;
      pc_load_q <= 1'b0;
      pc_val_q <= '0;
      ctx_q <= 1'b0;
      st_out_q <= '0;
      rtc_add_q <= 1'b0;
      rtc_val_q <= '0;
    end else begin
      svc_q <= svc_d;
      tmr_q <= tmr_d;
      rtc_q <= rtc_d;
      pc_stk_q <= pc_stk_d;
      fsp_sh_q <= fsp_sh_d;
      st_sh_q <= st_sh_d;
      mode_sh_q <= mode_sh_d;
      w_sh_q <= w_sh_d;
      pc_load_q <= pc_load_d;
      pc_val_q <= pc_val_d;
      ctx_q <= ctx_d;
      st_out_q <= st_out_d;
      rtc_add_q <= rtc_add_d;
      rtc_val_q <= rtc_val_d;
    end
  end

  assign in_service = svc_q;
  assign pc_load = pc_load_q;
  assign pc_value = pc_val_q;
  assign ctx_load = ctx_q;
  assign fsp_out = fsp_sh_q;
  assign status_out = st_out_q;
  assign mode_out = mode_sh_q;
  assign w_out = w_sh_q;
  assign rtc_add = rtc_add_q;
  assign rtc_add_val = rtc_val_q;

  // checks
  a_sleep_entry: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(low_power) |-> $past(sleep_exec))
    else $error("low-power state entered without sleep instruction");
  a_wd_sleep: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!low_power && sleep_exec && watchdog_enable) |=> (watchdog_clear && timeout_flag_set
      && powerdown_flag_clr && low_power))
    else $error("watchdog sleep side effects missing");
  a_clk_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
    low_power |-> (main_clk_keep == !extended_config_word[pwic_pkg::CFG_CLK_KEEP_BIT]))
    else $error("main clock keep does not follow config bit");
  a_portb_wake: assert property (@(posedge core_clk) disable iff (sys_rst)
    (low_power && portb_active && !rst_pin_sync_q && !(watchdog_enable && watchdog_overflow))
      |=> (!low_power && pc_load && pc_value == PC_TOP))
    else $error("port-B wake did not load top address");
  a_pend_sticky: assert property (@(posedge core_clk) disable iff (sys_rst)
    (edge_bus.hit != 8'h00) |=> ((wake_pending_flags & $past(edge_bus.hit)) == $past(edge_bus.hit)))
    else $error("detected edge not latched as pending");
  a_swap_read: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cfg_wr && sel_pend) |=> (cfg_swap && cfg_rdata == $past(wake_pending_flags)))
    else $error("pending swap returned wrong value");
  a_enable_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cfg_wr && mode_reg == pwic_pkg::MODE_EN) |=> (wake_enable_mask == $past(cfg_wdata)) && !cfg_swap)
    else $error("enable mask write failed");
  a_block_nest: assert property (@(posedge core_clk) disable iff (sys_rst)
    (in_service && !ret) |=> (in_service && !irq_req))
    else $error("interrupt requested during service");
  a_ack_vector: assert property (@(posedge core_clk) disable iff (sys_rst)
    take |=> (in_service && pc_load && pc_value == PC_VECTOR
      && status_out[pwic_pkg::STATUS_PAGE_LSB +: pwic_pkg::PAGE_BITS] == 3'h0))
    else $error("acknowledge did not vector to zero with clear page bits");
  a_return_pc: assert property (@(posedge core_clk) disable iff (sys_rst)
    ret |=> (!in_service && ctx_load && pc_value == $past(pc_stk_q) && rtc_add
      == $past(return_irq_add_counter)))
    else $error("return did not restore context");
  a_timer_drop: assert property (@(posedge core_clk) disable iff (sys_rst)
    (in_service && !tmr_q && !ret) |=> !tmr_q)
    else $error("timer event during service was kept");
  c_portb_irq: cover property (@(posedge core_clk) disable iff (sys_rst) take && portb_active);
  c_sleep_wake: cover property (@(posedge core_clk) disable iff (sys_rst)
    low_power ##1 !low_power && pc_load);
  c_ret_add: cover property (@(posedge core_clk) disable iff (sys_rst)
    ret && return_irq_add_counter);
endmodule

//--- sim/pwic_core_model.sv
// core-side partner: drives the port-B pins and acknowledges interrupt requests
module pwic_core_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic irq_req,
  input wire logic ack_en,
  input wire logic [3:0] ack_delay,
  input wire logic [7:0] pin_lvl,
  output logic irq_ack,
  output logic [7:0] second_port_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  assign second_port_pins = pin_lvl;
  // ack_delay lets the bench answer promptly or after a few idle cycles
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_ack <= 1'h0;
      wait_cnt <= 4'h0;
    end else begin
      irq_ack <= 1'h0;
      if (!irq_req || irq_ack)
        wait_cnt <= 4'h0;
      else if (ack_en && wait_cnt >= ack_delay)
        irq_ack <= 1'h1;
      else
        wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

//--- sim/tb.sv
// self-checking bench for the power-down, wake-up and interrupt sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [11:0] pc; logic [7:0] st; logic chk;} pwic_exp_t;
  logic core_clk = 1'h0;
  logic sys_rst = 1'h1;
  logic external_reset_pin = 1'h0, sleep_exec = 1'h0, watchdog_enable = 1'h1;
  logic watchdog_overflow = 1'h0, cfg_wr = 1'h0, rtc_rollover = 1'h0, rtc_irq_enable = 1'h0;
  logic return_from_irq = 1'h0, return_irq_add_counter = 1'h0, ack_en = 1'h0;
  logic [11:0] extended_config_word = 12'h800, pc_in = 12'h000, pc_value, sv_pc;
  logic [7:0] mode_reg = 8'h00, cfg_wdata = 8'h00, fsp_in = 8'h00, status_in = 8'h00;
  logic [7:0] mode_in = 8'h00, w_in = 8'h00, pin_lvl = 8'h00;
  logic [5:0] timer_events = 6'h00;
  logic [3:0] ack_delay = 4'h0;
  logic irq_ack, irq_req, cfg_swap, pc_load, ctx_load, rtc_add, low_power, main_clk_keep;
  logic watchdog_clear, timeout_flag_set, powerdown_flag_clr, wake_reset, in_service;
  logic [7:0] second_port_pins, cfg_rdata, direction_reg, comparator_register, fsp_out;
  logic [7:0] status_out, mode_out, w_out, rtc_add_val, wake_pending_flags;
  logic [7:0] wake_enable_mask, wake_edge_select, sv_fsp, sv_st, sv_mode, sv_w;
  logic [31:0] rnd = 32'h000149f5;
  int fails = 0, checks = 0, wakes = 0;
  pwic_exp_t e;
  pwic_exp_t pc_q[$];
  logic [7:0] ctx_q[$], rtc_q[$], swap_q[$];

  pwic_top i_pwic_top (
    .core_clk(core_clk), .sys_rst(sys_rst), .second_port_pins(second_port_pins),
    .external_reset_pin(external_reset_pin), .sleep_exec(sleep_exec),
    .watchdog_enable(watchdog_enable), .watchdog_overflow(watchdog_overflow),
    .extended_config_word(extended_config_word), .cfg_wr(cfg_wr), .mode_reg(mode_reg),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_swap(cfg_swap),
    .direction_reg(direction_reg), .comparator_register(comparator_register),
    .rtc_rollover(rtc_rollover), .rtc_irq_enable(rtc_irq_enable),
    .timer_events(timer_events), .irq_req(irq_req), .irq_ack(irq_ack), .pc_in(pc_in),
    .fsp_in(fsp_in), .status_in(status_in), .mode_in(mode_in), .w_in(w_in),
    .return_from_irq(return_from_irq), .return_irq_add_counter(return_irq_add_counter),
    .pc_load(pc_load), .pc_value(pc_value), .ctx_load(ctx_load), .fsp_out(fsp_out),
    .status_out(status_out), .mode_out(mode_out), .w_out(w_out), .rtc_add(rtc_add),
    .rtc_add_val(rtc_add_val), .low_power(low_power), .main_clk_keep(main_clk_keep),
    .watchdog_clear(watchdog_clear), .timeout_flag_set(timeout_flag_set),
    .powerdown_flag_clr(powerdown_flag_clr), .wake_reset(wake_reset),
    .in_service(in_service), .wake_pending_flags(wake_pending_flags),
    .wake_enable_mask(wake_enable_mask), .wake_edge_select(wake_edge_select)
  );
  pwic_core_model i_pwic_core_model (
    .core_clk(core_clk), .sys_rst(sys_rst), .irq_req(irq_req), .ack_en(ack_en),
    .ack_delay(ack_delay), .pin_lvl(pin_lvl), .irq_ack(irq_ack),
    .second_port_pins(second_port_pins)
  );

  always #2.5 core_clk = ~core_clk;

  function automatic logic [31:0] next_rand();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction

  task automatic cmp12(input logic [11:0] act, input logic [11:0] exp);
    checks++;
    if (act !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, act, exp);
    end
  endtask

  task automatic cmp8(input logic [7:0] act, input logic [7:0] exp);
    cmp12({4'h0, act}, {4'h0, exp});
  endtask

  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // results are looked at mid-cycle, where registered pulses have settled
  always @(negedge core_clk) begin
    if (!sys_rst && wake_reset === 1'h1)
      wakes++;
    if (!sys_rst && cfg_swap === 1'h1)
      cmp8(cfg_rdata, swap_q.size() != 0 ? swap_q.pop_front() : ~cfg_rdata);
    if (!sys_rst && pc_load === 1'h1) begin
      e = '{pc: ~pc_value, st: 8'h00, chk: 1'h0};
      if (pc_q.size() != 0)
        e = pc_q.pop_front();
      cmp12(pc_value, e.pc);
      if (e.chk)
        cmp8(status_out, e.st);
    end
    if (!sys_rst && ctx_load === 1'h1) begin
      cmp8(fsp_out, ctx_q.size() != 0 ? ctx_q.pop_front() : ~fsp_out);
      cmp8(mode_out, ctx_q.size() != 0 ? ctx_q.pop_front() : ~mode_out);
      cmp8(w_out, ctx_q.size() != 0 ? ctx_q.pop_front() : ~w_out);
    end
    if (!sys_rst && rtc_add === 1'h1)
      cmp8(rtc_add_val, rtc_q.size() != 0 ? rtc_q.pop_front() : ~rtc_add_val);
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic cfg(input logic [7:0] mode, input logic [7:0] val, input logic [7:0] old);
    @(posedge core_clk);
    mode_reg <= mode;
    cfg_wdata <= val;
    cfg_wr <= 1'h1;
    if (mode == pwic_pkg::MODE_PEND || mode == pwic_pkg::MODE_PEND_ALT ||
        mode == pwic_pkg::MODE_CMP)
      swap_q.push_back(old);
    @(posedge core_clk);
    cfg_wr <= 1'h0;
  endtask

  task automatic pulse(input int sel);
    @(posedge core_clk);
    case (sel)
      0: sleep_exec <= 1'h1;
      1: return_from_irq <= 1'h1;
      2: return_irq_add_counter <= 1'h1;
      3: watchdog_overflow <= 1'h1;
      4: rtc_rollover <= 1'h1;
      default: timer_events <= 6'h01 << (sel - 5);
    endcase
    @(posedge core_clk);
    {sleep_exec, return_from_irq, return_irq_add_counter} <= 3'h0;
    {watchdog_overflow, rtc_rollover} <= 2'h0;
    timer_events <= 6'h00;
  endtask

  // pins pass a synchroniser, so give them time before looking
  task automatic pin(input logic [7:0] lvl);
    @(posedge core_clk);
    pin_lvl <= lvl;
    tick(6);
    @(negedge core_clk);
  endtask

  task automatic isr_enter();
    logic [31:0] r;
    logic [31:0] q;
    r = next_rand();
    q = next_rand();
    {sv_st, sv_fsp, sv_pc} = r[27:0];
    {sv_w, sv_mode} = q[15:0];
    pc_q.push_back('{pc: 12'h000, st: sv_st & ~(8'h07 << pwic_pkg::STATUS_PAGE_LSB), chk: 1'h1});
    @(posedge core_clk);
    {status_in, fsp_in, pc_in} <= r[27:0];
    {w_in, mode_in} <= q[15:0];
    ack_delay <= {2'h0, q[17:16]};
    ack_en <= 1'h1;
    for (int i = 0; i < 40 && in_service !== 1'h1; i++)
      @(negedge core_clk);
    cmp8({7'h0, in_service}, 8'h01);
    @(posedge core_clk);
    ack_en <= 1'h0;
  endtask

  task automatic isr_leave(input logic add);
    logic [31:0] r;
    r = next_rand();
    @(posedge core_clk);
    w_in <= r[7:0];
    pc_q.push_back('{pc: sv_pc, st: sv_st, chk: 1'h1});
    ctx_q.push_back(sv_fsp);
    ctx_q.push_back(sv_mode);
    ctx_q.push_back(sv_w);
    if (add)
      rtc_q.push_back(r[7:0]);
    pulse(add ? 2 : 1);
    @(negedge core_clk);
    cmp8({7'h0, in_service}, 8'h00);
  endtask

  initial begin
    logic [31:0] r;
    r = next_rand();
    tick(10);
    sys_rst <= 1'h0;
    @(negedge core_clk);
    cmp8(wake_enable_mask, 8'hff);
    cmp8(wake_edge_select, 8'hff);
    cfg(pwic_pkg::MODE_EDGE, 8'h01, 8'h00);
    cfg(pwic_pkg::MODE_PEND, 8'h00, pwic_pkg::PEND_RST);
    cfg(pwic_pkg::MODE_EN, 8'hfe, 8'h00);
    cfg(pwic_pkg::MODE_DIR, r[7:0], 8'h00);
    cfg(pwic_pkg::MODE_CMP, r[15:8], pwic_pkg::CMP_RST);
    cfg(pwic_pkg::MODE_CMP, r[23:16], r[15:8]);
    cfg(8'h07, 8'h3c, 8'h00);
    @(negedge core_clk);
    cmp8(wake_edge_select, 8'h01);
    cmp8(wake_enable_mask, 8'hfe);
    cmp8(direction_reg, r[7:0]);
    cmp8(comparator_register, r[23:16]);
    pin(8'h02);
    cmp8(wake_pending_flags, 8'h02);
    cmp8({7'h0, irq_req}, 8'h00);
    pin(8'h03);
    cmp8(wake_pending_flags, 8'h02);
    pin(8'h02);
    cmp8(wake_pending_flags, 8'h03);
    cmp8({7'h0, irq_req}, 8'h01);
    isr_enter();
    cfg(pwic_pkg::MODE_PEND, 8'h00, 8'h03);
    pin(8'h03);
    pin(8'h02);
    cmp8(wake_pending_flags, 8'h01);
    cmp8({7'h0, irq_req}, 8'h00);
    isr_leave(1'h0);
    cmp8({7'h0, irq_req}, 8'h01);
    isr_enter();
    cfg(pwic_pkg::MODE_PEND_ALT, 8'h00, 8'h01);
    pulse(5);
    isr_leave(1'h1);
    pulse(4);
    tick(3);
    @(negedge core_clk);
    cmp8({7'h0, irq_req}, 8'h00);
    @(posedge core_clk);
    rtc_irq_enable <= 1'h1;
    // rollover first, then all six timer sources, alternating both returns
    for (int k = 4; k < 11; k++) begin
      pulse(k);
      isr_enter();
      isr_leave(k[0]);
    end
    cmp8({7'h0, low_power}, 8'h00);
    pulse(0);
    @(negedge core_clk);
    cmp8({4'h0, low_power, watchdog_clear, timeout_flag_set, powerdown_flag_clr}, 8'h0f);
    cmp8({7'h0, main_clk_keep}, 8'h00);
    pin(8'h03);
    cmp8({7'h0, low_power}, 8'h01);
    pc_q.push_back('{pc: 12'hfff, st: 8'h00, chk: 1'h0});
    pin(8'h02);
    cmp8({7'h0, low_power}, 8'h00);
    cfg(pwic_pkg::MODE_PEND, 8'h00, 8'h01);
    @(posedge core_clk);
    extended_config_word <= 12'h000;
    pulse(0);
    @(negedge core_clk);
    cmp8({7'h0, main_clk_keep}, 8'h01);
    pulse(3);
    tick(2);
    @(negedge core_clk);
    cmp8({low_power, 7'(wakes)}, 8'h01);
    @(posedge core_clk);
    watchdog_enable <= 1'h0;
    pulse(0);
    @(negedge core_clk);
    cmp8({6'h0, watchdog_clear, low_power}, 8'h01);
    @(posedge core_clk);
    external_reset_pin <= 1'h1;
    tick(6);
    external_reset_pin <= 1'h0;
    tick(4);
    @(negedge core_clk);
    cmp8({low_power, 7'(wakes)}, 8'h02);
    cmp8(8'(pc_q.size() + ctx_q.size() + rtc_q.size() + swap_q.size()), 8'h00);
    conclude();
  end

  initial begin
    #60000;
    fails++;
    conclude();
  end
endmodule
